// ### pkg/swe_defs.vh
// constants for the suspend wake event logic
`ifndef SWE_DEFS_VH
`define SWE_DEFS_VH
`define SWE_SEL_L0 2'h0
`define SWE_SEL_L1 2'h1
`define SWE_SEL_L2 2'h2
`define SWE_SEL_L3 2'h3
`define SWE_SEL_RESET 2'h2
`define SWE_ST_NOPWR 6'h01
`define SWE_ST_NORMAL 6'h02
`define SWE_ST_L0 6'h04
`define SWE_ST_L1 6'h08
`define SWE_ST_L2 6'h10
`define SWE_ST_L3 6'h20
`define SWE_PINS 11
`define SWE_PIN_LINK 7
`define SWE_WAKEUP_STATUS_FIELD_ED 0
`define SWE_WAKEUP_STATUS_FIELD_LAN 1
`endif

// ### rtl/swe_wake_logic.v
// suspend/wake state machine and wake event qualification
`timescale 1ns/1ns
`include "swe_defs.vh"
module swe_wake_logic
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // usb side
  input wire bus_voltage_detect,
  input wire usb_suspend,
  input wire usb_resume,
  output wire remote_wake,
  // configuration
  input wire [1:0] suspend_select_wr_data,
  input wire suspend_select_wr,
  input wire lan_wake_enable,
  input wire energy_wake_enable,
  input wire internal_phy_mode,
  input wire link_up_wake_select,
  input wire [10:0] pin_wake_enable,
  input wire [10:0] pin_wake_polarity,
  // mac wake enables
  input wire unicast_wake_enable,
  input wire magic_wake_enable,
  input wire wake_frame_enable,
  input wire perfect_dest_wake_enable,
  input wire broadcast_wake_enable,
  // events
  input wire unicast_event,
  input wire magic_event,
  input wire wake_frame_event,
  input wire perfect_dest_event,
  input wire broadcast_event,
  input wire filter_pass_frame,
  input wire phy_energy_detect,
  input wire phy_link_up,
  input wire [10:0] pin_in,
  // status clear (write one to clear)
  input wire [1:0] wakeup_status_clear,
  input wire [10:0] pin_event_clear,
  // status
  output wire [1:0] suspend_select,
  output wire [1:0] wakeup_status_field,
  output wire [10:0] pin_event_flags,
  output wire [5:0] power_state,
  output wire clocks_running,
  output wire rx_frame_drop
);

reg [5:0] state_reg, state_next;
reg [1:0] sel_reg;
reg [1:0] wakeup_status_field_reg;
reg [10:0] pflag_reg;
reg wake_reg;
reg [2:0] vbus_sync_reg;
reg vbus_reg;
reg [10:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
reg link_s1_reg, link_s2_reg, link_s3_reg, link_reg;
reg link_prev_reg;

// one-hot power states
localparam [5:0] ST_NOPWR = `SWE_ST_NOPWR;
localparam [5:0] ST_NORMAL = `SWE_ST_NORMAL;
localparam [5:0] ST_L0 = `SWE_ST_L0;
localparam [5:0] ST_L1 = `SWE_ST_L1;
localparam [5:0] ST_L2 = `SWE_ST_L2;
localparam [5:0] ST_L3 = `SWE_ST_L3;

// ----------------------------------------
// input synchronisers
// ----------------------------------------
always @(posedge sys_clk or negedge resetn)
begin
  if (!resetn)
  begin
    vbus_sync_reg <= 3'h0;
    vbus_reg <= 1'b0;
    pin_s1_reg <= 11'h000;
    pin_s2_reg <= 11'h000;
    pin_s3_reg <= 11'h000;
    pin_reg <= 11'h000;
    link_s1_reg <= 1'b0;
    link_s2_reg <= 1'b0;
    link_s3_reg <= 1'b0;
    link_reg <= 1'b0;
    link_prev_reg <= 1'b0;
  end
  else
  begin
    vbus_sync_reg <= {vbus_sync_reg[1:0], bus_voltage_detect};
    if (vbus_sync_reg[1] == vbus_sync_reg[2])
      vbus_reg <= vbus_sync_reg[2];
    pin_s1_reg <= pin_in;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
    pin_reg <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
    link_s1_reg <= phy_link_up;
    link_s2_reg <= link_s1_reg;
    link_s3_reg <= link_s2_reg;
    if (link_s2_reg == link_s3_reg)
      link_reg <= link_s3_reg;
    link_prev_reg <= link_reg;
  end
end

// ----------------------------------------
// event qualification
// ----------------------------------------
wire in_l0 = (state_reg == ST_L0);
wire in_l1 = (state_reg == ST_L1);
wire in_l3 = (state_reg == ST_L3);
wire suspended = in_l0 | in_l1 | in_l3 | (state_reg == ST_L2);
wire link_rise = link_reg & ~link_prev_reg;

wire mac_any_enable = unicast_wake_enable | magic_wake_enable | wake_frame_enable |
  perfect_dest_wake_enable | broadcast_wake_enable;
wire lan_composite = (unicast_wake_enable & unicast_event) |
  (magic_wake_enable & magic_event) | (wake_frame_enable & wake_frame_event) |
  (perfect_dest_wake_enable & perfect_dest_event) |
  (broadcast_wake_enable & broadcast_event);
// good frame only counts with no mac wake enable set; lan_wake_enable not used
wire good_frame = filter_pass_frame & ~mac_any_enable;
// a mac enable during level three throws frames away
assign rx_frame_drop = in_l3 & mac_any_enable;

// pin active levels after polarity
wire [10:0] pin_active = pin_reg ~^ pin_wake_polarity;
wire [10:0] pin_usable = {3'h7, {8{internal_phy_mode}}};
reg [10:0] pin_event;
always @*
begin
  pin_event = pin_active & pin_wake_enable & pin_usable;
  // link up replaces the pin's own level on pin 7
  if (link_up_wake_select)
    pin_event[`SWE_PIN_LINK] = link_rise & (in_l0 | in_l3) & pin_usable[`SWE_PIN_LINK];
end

// pin flags are only set while suspended; elsewhere events are ignored
wire [10:0] pin_set = suspended ? pin_event : 11'h000;
wire lan_set = (in_l0 & lan_wake_enable & lan_composite) | (in_l3 & good_frame);
wire ed_set = in_l1 & energy_wake_enable & phy_energy_detect;

// ----------------------------------------
// status flags: set wins over clear
// ----------------------------------------
always @(posedge sys_clk or negedge resetn)
begin
  if (!resetn)
  begin
    wakeup_status_field_reg <= 2'h0;
    pflag_reg <= 11'h000;
  end
  else
  begin
    pflag_reg <= (pflag_reg & ~pin_event_clear) | pin_set;
    wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_LAN] <= (wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_LAN] & ~wakeup_status_clear[`SWE_WAKEUP_STATUS_FIELD_LAN])
      | lan_set;
    wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_ED] <= (wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_ED] & ~wakeup_status_clear[`SWE_WAKEUP_STATUS_FIELD_ED])
      | ed_set;
  end
end

// pending pin flags wake a freshly suspended device at once; a status flag only where its level and enable could set it
wire pending = (|pflag_reg) | (in_l3 & wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_LAN]) |
  (in_l0 & lan_wake_enable & wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_LAN]) |
  (in_l1 & energy_wake_enable & wakeup_status_field_reg[`SWE_WAKEUP_STATUS_FIELD_ED]);
wire wake_now = suspended & (pending | (|pin_set) | lan_set | ed_set);

// ----------------------------------------
// power state machine
// ----------------------------------------
always @*
begin
  state_next = state_reg;
  case (state_reg)
    ST_NOPWR:
      if (vbus_reg)
        state_next = ST_NORMAL;
    ST_NORMAL:
      if (usb_suspend)
      begin
        case (sel_reg)
          `SWE_SEL_L0: state_next = ST_L0;
          `SWE_SEL_L1: state_next = ST_L1;
          `SWE_SEL_L2: state_next = ST_L2;
          default: state_next = ST_L3;
        endcase
      end
    ST_L0, ST_L1, ST_L2, ST_L3:
      if (usb_resume || wake_now)
        state_next = ST_NORMAL;
    default:
      state_next = ST_NORMAL;
  endcase
  // losing bus voltage overrides everything
  if (!vbus_reg)
    state_next = ST_NOPWR;
end

always @(posedge sys_clk or negedge resetn)
begin
  if (!resetn)
  begin
    state_reg <= ST_NOPWR;
    sel_reg <= `SWE_SEL_RESET;
    wake_reg <= 1'b0;
  end
  else
  begin
    state_reg <= state_next;
    if (suspend_select_wr)
      sel_reg <= suspend_select_wr_data;
    // one-cycle remote wake request, only for device-detected events
    wake_reg <= wake_now & ~usb_resume & vbus_reg;
  end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign remote_wake = wake_reg;
assign suspend_select = sel_reg;
assign wakeup_status_field = wakeup_status_field_reg;
assign pin_event_flags = pflag_reg;
assign power_state = state_reg;
// level three keeps every clock on; no extra rx buffering is added
assign clocks_running = (state_reg == ST_NORMAL) | in_l3;

endmodule

// ### sim/swe_wake_checker.sv
// concurrent checks on the suspend wake logic ports
`timescale 1ns/1ns
module swe_chk
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // host side
  input wire usb_suspend,
  input wire usb_resume,
  input wire remote_wake,
  input wire [1:0] suspend_select,
  input wire filter_pass_frame,
  // status
  input wire [10:0] pin_event_clear,
  input wire [10:0] pin_event_flags,
  input wire [1:0] wakeup_status_field,
  input wire [5:0] power_state,
  input wire clocks_running,
  input wire rx_frame_drop
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // a pending pin or lan flag rewakes level three at once, so entry is judged only with no flag left
  wire pend = |{pin_event_flags, wakeup_status_field};
  sequence s_frame;
    power_state == 6'h20 && filter_pass_frame && !rx_frame_drop && !usb_resume;
  endsequence
  sequence s_left;
    $past(power_state) != 6'h02 && power_state == 6'h02;
  endsequence
  a_l3_entry:
    assert property (power_state == 6'h02 && usb_suspend && suspend_select == 2'h3 && !pend
      |=> power_state == 6'h20) else $error("no entry");
  a_l3_clocks:
    assert property (power_state == 6'h20 |-> clocks_running) else $error("clocks off");
  a_drop_scope:
    assert property (rx_frame_drop |-> power_state == 6'h20) else $error("bad drop");
  a_good_frame:
    assert property (s_frame |=> wakeup_status_field[1] && remote_wake) else $error("frame");
  a_wake_pulse:
    assert property (remote_wake |=> !remote_wake) else $error("long pulse");
  a_wake_leave:
    assert property (remote_wake |-> s_left) else $error("stray wake");
  a_host_resume:
    assert property (|power_state[5:2] && usb_resume |=> power_state == 6'h02)
      else $error("resume");
  a_flag_latch:
    assert property (1'b1 |=> ($past(pin_event_flags) & ~$past(pin_event_clear)
      & ~pin_event_flags) == 11'h000) else $error("flag lost");
endmodule
bind swe_wake_logic swe_chk u_swe_chk (.*);

// ### sim/swe_host_model.sv
// usb host and driver model for the wake logic
`timescale 1ns/1ns
module swe_host
(
  // clock
  input wire sys_clk,
  // to the device
  output logic bus_voltage_detect = 0,
  output logic usb_suspend = 0,
  output logic usb_resume = 0,
  output logic [1:0] suspend_select_wr_data = 0,
  output logic suspend_select_wr = 0,
  output logic [1:0] wakeup_status_clear = 0,
  output logic [10:0] pin_event_clear = 0
);
  // bus voltage appears a little after reset, off the sampling edge
  initial
  begin
    repeat (10) @(negedge sys_clk);
    bus_voltage_detect = 1;
  end
  // c low leaves flags pending on purpose
  task enter(input logic [1:0] s, input logic c);
    @(negedge sys_clk);
    suspend_select_wr_data = s;
    suspend_select_wr = 1;
    wakeup_status_clear = {2{c}};
    pin_event_clear = {11{c}};
    @(negedge sys_clk);
    {suspend_select_wr, wakeup_status_clear, pin_event_clear} = 0;
    usb_suspend = 1;
    @(negedge sys_clk);
    usb_suspend = 0;
  endtask
  task resume;
    @(negedge sys_clk);
    usb_resume = 1;
    @(negedge sys_clk);
    usb_resume = 0;
  endtask
endmodule

// ### sim/swe_wake_logic_bench.sv
// self-checking bench for the suspend wake logic
`timescale 1ns/1ns
module swe_wake_logic_bench;
  logic sys_clk = 0, resetn = 0, lan_wake_enable = 0, energy_wake_enable = 0;
  logic internal_phy_mode = 1, link_up_wake_select = 0, filter_pass_frame = 0;
  logic phy_energy_detect = 0, phy_link_up = 0;
  logic [4:0] me = 0, mv = 0;
  logic [10:0] pin_wake_enable = 0, pin_wake_polarity = 11'h7FF, pin_in = 0;
  wire bus_voltage_detect, usb_suspend, usb_resume, suspend_select_wr, remote_wake;
  wire clocks_running, rx_frame_drop;
  wire [1:0] suspend_select_wr_data, wakeup_status_clear, suspend_select, wakeup_status_field;
  wire [10:0] pin_event_clear, pin_event_flags;
  wire [5:0] power_state;
  int miscompares = 0, checked = 0;
  always #10 sys_clk = ~sys_clk;
  swe_host u_swe_host (.*);
  swe_wake_logic u_swe_wake_logic (.*, .unicast_wake_enable(me[0]), .magic_wake_enable(me[1]),
    .wake_frame_enable(me[2]), .perfect_dest_wake_enable(me[3]), .broadcast_wake_enable(me[4]),
    .unicast_event(mv[0]), .magic_event(mv[1]), .wake_frame_event(mv[2]),
    .perfect_dest_event(mv[3]), .broadcast_event(mv[4]));
  task chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for normal; a refused event leaves the state as it was
  task wake(input logic [5:0] e);
    for (int i = 0; i < 8 && power_state !== 6'h02; i++) @(negedge sys_clk);
    chk(power_state, e);
  endtask
  task t_levels;
    for (int s = 0; s < 3; s++)
    begin
      u_swe_host.enter(s[1:0], 1'b1);
      chk(suspend_select, s[1:0]);
      filter_pass_frame = 1;
      wake(6'h04 << s);
      filter_pass_frame = 0;
      u_swe_host.resume();
      wake(6'h02);
      chk(remote_wake, 1'b0);
    end
  endtask
  task t_mac;
    lan_wake_enable = 1;
    for (int i = 0; i < 5; i++)
    begin
      u_swe_host.enter(2'h0, 1'b1);
      mv = 5'h1F ^ (5'h01 << i);
      me = 5'h01 << i;
      wake(6'h04);
      mv = me;
      wake(6'h02);
      {me, mv} = 0;
    end
  endtask
  task t_frame;
    lan_wake_enable = 0;
    u_swe_host.enter(2'h3, 1'b1);
    chk(power_state, 6'h20);
    chk(clocks_running, 1'b1);
    me = 5'h02;
    filter_pass_frame = 1;
    wake(6'h20);
    chk(rx_frame_drop, 1'b1);
    me = 0;
    wake(6'h02);
    chk(remote_wake, 1'b1);
    filter_pass_frame = 0;
    chk(wakeup_status_field, 2'h2);
    chk(suspend_select, 2'h3);
    // the lan wake enable bit must not matter for a good frame
    lan_wake_enable = 1;
    u_swe_host.enter(2'h3, 1'b1);
    filter_pass_frame = 1;
    wake(6'h02);
    filter_pass_frame = 0;
    chk(wakeup_status_field, 2'h2);
    lan_wake_enable = 0;
  endtask
  task t_pins;
    internal_phy_mode = 0;
    pin_wake_enable = 11'h208;
    u_swe_host.enter(2'h2, 1'b1);
    pin_in = 11'h008;
    wake(6'h10);
    pin_in = 11'h208;
    wake(6'h02);
    pin_in = 0;
    chk(pin_event_flags, 11'h200);
    // let the pin settle low so only the pending flag can wake
    repeat (8) @(negedge sys_clk);
    u_swe_host.enter(2'h2, 1'b0);
    wake(6'h02);
  endtask
  task t_link;
    internal_phy_mode = 1;
    link_up_wake_select = 1;
    pin_wake_enable = 11'h080;
    u_swe_host.enter(2'h3, 1'b1);
    phy_link_up = 1;
    wake(6'h02);
    chk(pin_event_flags, 11'h080);
    phy_link_up = 0;
    // with link select set the pin level is ignored; cleared, the pin wakes
    u_swe_host.enter(2'h3, 1'b1);
    pin_in = 11'h080;
    wake(6'h20);
    link_up_wake_select = 0;
    wake(6'h02);
    pin_in = 0;
    chk(pin_event_flags, 11'h080);
    pin_wake_enable = 0;
    energy_wake_enable = 1;
    u_swe_host.enter(2'h1, 1'b1);
    phy_energy_detect = 1;
    wake(6'h02);
    chk(wakeup_status_field, 2'h1);
    phy_energy_detect = 0;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1;
    repeat (20) @(negedge sys_clk);
    chk(power_state, 6'h02);
    chk(suspend_select, 2'h2);
    t_levels();
    t_mac();
    t_frame();
    t_pins();
    t_link();
    conclude();
  end
endmodule
